// >>> src/reset_pin_config_regs.svh
// constants for the reset-time pin configuration selector
// assumes the includer has the usual timescale and nettype settings
`ifndef RESET_PIN_CONFIG_REGS_SVH
`define RESET_PIN_CONFIG_REGS_SVH
`define SEL_BIT_WIDTH       1
`define SEL_BIT_BOOT        0
`define SEL_BIT_MODE        1
`define SEL_BIT_CTRL        2
`define SEL_BIT_HIGH_LO     3
`define SEL_BIT_HIGH_HI     7
`define SEL_BIT_PORT_E      8
`define SEL_BIT_PORT_F      9
`define SEL_BIT_EMUL        10
`define SEL_BIT_ROM_EMUL    13
`define CHIP_SEL_RESET      5'h1F
`define FIRST_CYCLE_SYSTEM_CLOCK_OUTPUT  4'hA
`define SYSTEM_CLOCK_OUTPUT_DIV          4'h2
`endif

// >>> src/reset_pin_config_pkg.sv
// types for the reset-time pin configuration selector
// assumes nothing of its surroundings
package reset_pin_config_pkg;
    typedef enum logic [1:0] {
        BUS_WIDE   = 2'b00,
        BUS_NARROW = 2'b01,
        BUS_SINGLE = 2'b10
    } bus_mode_t;
    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_WAIT   = 2'b10,
        ST_RUN    = 2'b11
    } seq_state_t;
endpackage

// >>> src/reset_pin_config_select.sv
// reset-time pin function selector: latches mode-select levels at reset
// release and drives the pin function selects of the shared pins
// assumes rst_i is synchronous to clk_i and the data pins are raw pins
`include "reset_pin_config_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module reset_pin_config_select (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        bus_fault_input_i,
    input  wire logic [15:0] data_pins_i,
    input  wire logic [4:0]  select_pin_assign_reg_i,
    input  wire logic        select_pin_assign_wr_i,
    input  wire logic        low_address_disable_wr_i,
    input  wire logic        low_address_disable_val_i,
    input  wire logic        port_reg_access_i,
    input  wire logic        rom_array_access_i,
    output logic             data_pullup_en_o,
    output logic             system_clock_output_o,
    output logic             config_valid_o,
    output logic             bus_cycle_allowed_o,
    output logic [1:0]       bus_mode_o,
    output logic             emulator_mode_o,
    output logic             addr_high_is_addr_o,
    output logic             data_low_is_port_h_o,
    output logic             data_high_is_port_g_o,
    output logic             addr_mid_is_ports_ab_o,
    output logic [4:0]       high_pins_chip_select_o,
    output logic             low_address_disable_o,
    output logic             boot_memory_select_wide_o,
    output logic             chip_select_zero_en_o,
    output logic             chip_select_three_en_o,
    output logic             chip_select_five_en_o,
    output logic             function_code_one_en_o,
    output logic             fc_cs_are_port_c_o,
    output logic             bus_ctrl_is_port_e_o,
    output logic             irq_clk_is_port_f_o,
    output logic             bus_grant_en_o,
    output logic             grant_acknowledge_en_o,
    output logic             emulation_port_select_o,
    output logic             emulation_rom_select_o
);
    reset_pin_config_pkg::seq_state_t state_r;
    reset_pin_config_pkg::seq_state_t state_nxt;
    reset_pin_config_pkg::bus_mode_t  mode_r;
    reset_pin_config_pkg::bus_mode_t  mode_nxt;
    logic [16:0] sync1_r;
    logic [16:0] sync2_r;
    logic [16:0] sync3_r;
    logic [16:0] stable_r;
    logic [16:0] stable_nxt;
    logic [15:0] strap_r;
    logic [15:0] strap_nxt;
    logic        fault_r;
    logic        fault_nxt;
    logic [3:0]  div_r;
    logic [3:0]  div_nxt;
    logic        clk_out_r;
    logic        clk_out_nxt;
    logic [3:0]  edges_r;
    logic [3:0]  edges_nxt;
    logic [4:0]  chip_sel_r;
    logic [4:0]  chip_sel_nxt;
    logic        abd_r;
    logic        abd_nxt;
    logic        emul_r;
    logic        emul_nxt;
    logic        port_sel_r;
    logic        port_sel_nxt;
    logic        rom_sel_r;
    logic        rom_sel_nxt;
    logic        tick;
    logic        narrow;
    logic        single;

    // three-stage pin synchroniser; only stages two and three are compared
    always_ff @(posedge clk_i) begin
        sync1_r <= {bus_fault_input_i, data_pins_i};
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    genvar g;
    generate
        for (g = 0; g < 17; g = g + 1) begin : g_filt
            always_comb begin
                stable_nxt[g] = stable_r[g];
                if (sync2_r[g] == sync3_r[g]) begin
                    stable_nxt[g] = sync3_r[g];
                end
            end
        end
    endgenerate

    // clock-out divider gives the edge count for the first bus cycle
    always_comb begin
        div_nxt     = div_r + 4'h1;
        clk_out_nxt = clk_out_r;
        tick        = 1'b0;
        if (div_r == `SYSTEM_CLOCK_OUTPUT_DIV - 4'h1) begin
            div_nxt     = 4'h0;
            clk_out_nxt = ~clk_out_r;
            tick        = clk_out_r;
        end
    end

    always_comb begin
        state_nxt    = state_r;
        mode_nxt     = mode_r;
        strap_nxt    = strap_r;
        fault_nxt    = fault_r;
        edges_nxt    = edges_r;
        chip_sel_nxt = chip_sel_r;
        abd_nxt      = abd_r;
        emul_nxt     = emul_r;
        unique case (state_r)
            reset_pin_config_pkg::ST_RESET: begin
                state_nxt = reset_pin_config_pkg::ST_SAMPLE;
            end
            reset_pin_config_pkg::ST_SAMPLE: begin
                // one-time capture of the mode levels at release
                strap_nxt = stable_r[15:0];
                fault_nxt = stable_r[16];
                edges_nxt = 4'h0;
                state_nxt = reset_pin_config_pkg::ST_WAIT;
                if (!stable_r[16]) begin
                    mode_nxt = reset_pin_config_pkg::BUS_SINGLE;
                    abd_nxt  = 1'b1;
                    emul_nxt = 1'b0;
                end else if (stable_r[`SEL_BIT_MODE]) begin
                    mode_nxt = reset_pin_config_pkg::BUS_NARROW;
                    abd_nxt  = 1'b0;
                    emul_nxt = 1'b0;
                end else begin
                    mode_nxt = reset_pin_config_pkg::BUS_WIDE;
                    abd_nxt  = 1'b0;
                    emul_nxt = ~stable_r[`SEL_BIT_EMUL];
                end
                chip_sel_nxt = `CHIP_SEL_RESET;
            end
            reset_pin_config_pkg::ST_WAIT: begin
                // bus stays idle for ten clock-out cycles
                if (tick) begin
                    edges_nxt = edges_r + 4'h1;
                    if (edges_r == `FIRST_CYCLE_SYSTEM_CLOCK_OUTPUT - 4'h1) begin
                        state_nxt = reset_pin_config_pkg::ST_RUN;
                    end
                end
            end
            reset_pin_config_pkg::ST_RUN: begin
            end
        endcase
        if (state_r != reset_pin_config_pkg::ST_RESET
            && state_r != reset_pin_config_pkg::ST_SAMPLE) begin
            if (select_pin_assign_wr_i && !single) begin
                chip_sel_nxt = select_pin_assign_reg_i;
            end
            if (low_address_disable_wr_i && single) begin
                abd_nxt = low_address_disable_val_i;
            end
        end
    end

    assign narrow = (mode_r == reset_pin_config_pkg::BUS_NARROW);
    assign single = (mode_r == reset_pin_config_pkg::BUS_SINGLE);

    // emulation selects registered from the qualified accesses
    always_comb begin
        port_sel_nxt = emul_r && port_reg_access_i;
        rom_sel_nxt  = emul_r && rom_array_access_i
                       && !strap_r[`SEL_BIT_ROM_EMUL];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= reset_pin_config_pkg::ST_RESET;
            mode_r     <= reset_pin_config_pkg::BUS_WIDE;
            stable_r   <= 17'h1FFFF;
            strap_r    <= 16'hFFFF;
            fault_r    <= 1'b1;
            div_r      <= 4'h0;
            clk_out_r  <= 1'b0;
            edges_r    <= 4'h0;
            chip_sel_r <= `CHIP_SEL_RESET;
            abd_r      <= 1'b0;
            emul_r     <= 1'b0;
            port_sel_r <= 1'b0;
            rom_sel_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            mode_r     <= mode_nxt;
            stable_r   <= stable_nxt;
            strap_r    <= strap_nxt;
            fault_r    <= fault_nxt;
            div_r      <= div_nxt;
            clk_out_r  <= clk_out_nxt;
            edges_r    <= edges_nxt;
            chip_sel_r <= chip_sel_nxt;
            abd_r      <= abd_nxt;
            emul_r     <= emul_nxt;
            port_sel_r <= port_sel_nxt;
            rom_sel_r  <= rom_sel_nxt;
        end
    end

    // pull-ups only while the straps are still being read
    assign data_pullup_en_o      = (state_r == reset_pin_config_pkg::ST_RESET)
                                 || (state_r == reset_pin_config_pkg::ST_SAMPLE);
    assign system_clock_output_o = clk_out_r;
    assign config_valid_o        = (state_r == reset_pin_config_pkg::ST_WAIT)
                                 || (state_r == reset_pin_config_pkg::ST_RUN);
    // the board must have let go of the data lines by now
    assign bus_cycle_allowed_o   = (state_r == reset_pin_config_pkg::ST_RUN)
                                 && !single;
    assign bus_mode_o            = mode_r;
    assign emulator_mode_o       = emul_r;
    assign addr_high_is_addr_o   = ~single;
    assign data_low_is_port_h_o  = ~(mode_r == reset_pin_config_pkg::BUS_WIDE);
    assign data_high_is_port_g_o = single;
    assign addr_mid_is_ports_ab_o = single;
    assign high_pins_chip_select_o = single ? 5'h00 : chip_sel_r;
    assign low_address_disable_o = abd_r;
    // the wide-bus boot size strap is ignored in narrow mode
    assign boot_memory_select_wide_o = single ? 1'b1 :
                                       narrow ? 1'b0 :
                                       strap_r[`SEL_BIT_BOOT];
    assign chip_select_zero_en_o  = single | narrow
                                  | strap_r[`SEL_BIT_CTRL];
    assign chip_select_three_en_o = ~single & (narrow
                                  | strap_r[`SEL_BIT_CTRL]);
    assign chip_select_five_en_o  = ~single & (narrow
                                  | strap_r[`SEL_BIT_CTRL]);
    assign function_code_one_en_o = ~single;
    assign fc_cs_are_port_c_o     = single;
    // single-chip forces every port regardless of straps
    assign bus_ctrl_is_port_e_o   = single
                                  | ~strap_r[`SEL_BIT_PORT_E];
    assign irq_clk_is_port_f_o    = single
                                  | ~strap_r[`SEL_BIT_PORT_F];
    assign bus_grant_en_o         = ~emul_r;
    assign grant_acknowledge_en_o = ~emul_r;
    assign emulation_port_select_o = port_sel_r;
    assign emulation_rom_select_o  = rom_sel_r;
    // unused capture bit kept for observability of the stored fault level
    logic unused_fault;
    assign unused_fault = fault_r;
endmodule // reset_pin_config_select
`default_nettype wire

// >>> testbench/board_straps.sv
// board model: mode-select drivers on the data lines and the fault strap
// assumes pullup_en_i is high only while the device samples its straps
`timescale 1ns/10ps
`default_nettype none
module board_straps (
    input  wire logic        clk_i,
    input  wire logic        pullup_en_i,
    input  wire logic        fault_i,
    input  wire logic [15:0] straps_i,
    output logic             fault_o,
    output logic [15:0]      data_o
);
    logic [15:0] junk_r = 16'hA5C3;
    // released lines carry bus traffic, never the old strap levels
    always_ff @(posedge clk_i) begin
        junk_r <= ~junk_r;
    end
    // lines left high by the pull-ups, low ones driven actively
    assign data_o  = pullup_en_i ? straps_i : junk_r;
    assign fault_o = fault_i; // held low for all of single-chip use
endmodule // board_straps
`default_nettype wire

// >>> testbench/rpc_sva.sv
// assertions for the reset pin configuration selector
// bound into every selector instance; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module rpc_sva (
    input wire logic       clk_i, rst_i, port_reg_access_i,
    input wire logic       rom_array_access_i, system_clock_output_o,
    input wire logic       config_valid_o, bus_cycle_allowed_o,
    input wire logic [1:0] bus_mode_o,
    input wire logic       emulator_mode_o, data_low_is_port_h_o,
    input wire logic       data_high_is_port_g_o, addr_mid_is_ports_ab_o,
    input wire logic [4:0] high_pins_chip_select_o,
    input wire logic       low_address_disable_o, boot_memory_select_wide_o,
    input wire logic       chip_select_zero_en_o, function_code_one_en_o,
    input wire logic       bus_ctrl_is_port_e_o, irq_clk_is_port_f_o,
    input wire logic       bus_grant_en_o, fc_cs_are_port_c_o,
    input wire logic       emulation_port_select_o, emulation_rom_select_o,
    input wire logic       data_pullup_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       single;
    logic       narrow;
    logic [4:0] ticks_r;
    assign single = bus_mode_o == reset_pin_config_pkg::BUS_SINGLE;
    assign narrow = bus_mode_o == reset_pin_config_pkg::BUS_NARROW;
    // clock-out rising edges since the latch, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i || !config_valid_o) begin
            ticks_r <= 5'h00;
        end else if ($rose(system_clock_output_o) && ticks_r != 5'h1F) begin
            ticks_r <= ticks_r + 5'h01;
        end
    end
    a_single_ports: assert property (
        config_valid_o && single |-> data_low_is_port_h_o
        && data_high_is_port_g_o && addr_mid_is_ports_ab_o
        && bus_ctrl_is_port_e_o && irq_clk_is_port_f_o && fc_cs_are_port_c_o
        && boot_memory_select_wide_o && chip_select_zero_en_o
        && bus_grant_en_o && !bus_cycle_allowed_o)
        else $error("single-chip pin functions wrong");
    a_narrow_fixed: assert property (
        config_valid_o && narrow |-> !emulator_mode_o
        && !boot_memory_select_wide_o && chip_select_zero_en_o
        && function_code_one_en_o && bus_grant_en_o && data_low_is_port_h_o
        && !data_high_is_port_g_o && !addr_mid_is_ports_ab_o
        && !low_address_disable_o)
        else $error("8-bit pin functions wrong");
    a_latch_delay: assert property (
        $fell(rst_i) |-> !config_valid_o ##1 !config_valid_o ##1 config_valid_o)
        else $error("straps latched at wrong edge");
    a_config_hold: assert property (
        config_valid_o |=> $stable(bus_mode_o) && $stable(emulator_mode_o)
        && $stable(bus_ctrl_is_port_e_o) && $stable(irq_clk_is_port_f_o))
        else $error("configuration changed after latch");
    a_chip_sel_start: assert property (
        $rose(config_valid_o) && narrow |-> high_pins_chip_select_o == 5'h1F)
        else $error("high pins not chip selects");
    a_abd_start: assert property (
        $rose(config_valid_o) && single |-> low_address_disable_o)
        else $error("low address not disabled");
    a_pullup_reset: assert property (disable iff (1'b0)
        rst_i |=> data_pullup_en_o && !config_valid_o)
        else $error("pull-ups off during reset");
    a_first_cycle: assert property (
        $rose(bus_cycle_allowed_o) |-> ticks_r inside {5'h0A, 5'h0B})
        else $error("first bus cycle early or late");
    a_cycle_late: assert property (
        config_valid_o && !single && ticks_r == 5'h0C |-> bus_cycle_allowed_o)
        else $error("first bus cycle missing");
    a_port_select: assert property (
        emulator_mode_o && port_reg_access_i |=> emulation_port_select_o)
        else $error("port emulation select missing");
    a_rom_cause: assert property (
        emulation_rom_select_o |-> $past(rom_array_access_i) && emulator_mode_o)
        else $error("rom select without cause");
    cover property (config_valid_o && narrow);
    cover property (config_valid_o && single);
    cover property (emulation_rom_select_o);
endmodule // rpc_sva
bind reset_pin_config_select rpc_sva chk (.*);
`default_nettype wire

// >>> testbench/tb_reset_pin_config_select.sv
// bench for the reset pin configuration selector
// assumes the board model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module tb_reset_pin_config_select;
    typedef struct packed {
        logic f; logic [15:0] s; logic [1:0] m; logic e, pe, pf, w;
    } row_t;
    localparam row_t ROWS [6] = '{
        '{1'b1, 16'hFFFF, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 16'hFCFF, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0},
        '{1'b1, 16'hDBFD, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1},
        '{1'b1, 16'hFFFC, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 16'hFBFF, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 16'hFCFF, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1}};
    logic clk_i, rst_i, fault_drv, bus_fault_input_i, port_reg_access_i;
    logic rom_array_access_i, select_pin_assign_wr_i, low_address_disable_wr_i;
    logic low_address_disable_val_i, data_pullup_en_o, system_clock_output_o;
    logic config_valid_o, bus_cycle_allowed_o, emulator_mode_o;
    logic [15:0] data_pins_i, straps;
    logic [4:0] select_pin_assign_reg_i, high_pins_chip_select_o;
    logic [1:0] bus_mode_o;
    logic addr_high_is_addr_o, data_low_is_port_h_o, data_high_is_port_g_o;
    logic addr_mid_is_ports_ab_o, low_address_disable_o, chip_select_zero_en_o;
    logic boot_memory_select_wide_o, chip_select_three_en_o, bus_grant_en_o;
    logic chip_select_five_en_o, function_code_one_en_o, fc_cs_are_port_c_o;
    logic bus_ctrl_is_port_e_o, irq_clk_is_port_f_o, grant_acknowledge_en_o;
    logic emulation_port_select_o, emulation_rom_select_o;
    int n_errors = 0;
    int samples_checked = 0;
    reset_pin_config_select dut (.*);
    board_straps board (.clk_i(clk_i), .pullup_en_i(data_pullup_en_o),
        .fault_i(fault_drv), .straps_i(straps), .fault_o(bus_fault_input_i),
        .data_o(data_pins_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // straps must settle through the synchronisers before release
    task automatic boot(input logic f, input logic [15:0] s);
        int n = 0;
        rst_i = 1'b1;
        fault_drv = f;
        straps = s;
        repeat (16) tick();
        rst_i = 1'b0;
        while (config_valid_o !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (n == 20) n_errors++;
    endtask
    task automatic pulse_write(input logic abd, input logic v);
        low_address_disable_wr_i = abd;
        select_pin_assign_wr_i = !abd;
        low_address_disable_val_i = v;
        tick();
        low_address_disable_wr_i = 1'b0;
        select_pin_assign_wr_i = 1'b0;
        tick();
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        {rst_i, fault_drv, port_reg_access_i, rom_array_access_i} = 4'hF;
        {select_pin_assign_wr_i, low_address_disable_wr_i} = 2'h0;
        low_address_disable_val_i = 1'b0;
        select_pin_assign_reg_i = 5'h05;
        straps = 16'hFFFF;
        tick();
        {port_reg_access_i, rom_array_access_i} = 2'h0;
        foreach (ROWS[i]) begin
            boot(ROWS[i].f, ROWS[i].s);
            check({bus_mode_o, emulator_mode_o, bus_ctrl_is_port_e_o,
                irq_clk_is_port_f_o, boot_memory_select_wide_o},
                {ROWS[i].m, ROWS[i].e, ROWS[i].pe, ROWS[i].pf, ROWS[i].w});
        end
        boot(1'b1, 16'hDBFD);
        port_reg_access_i = 1'b1;
        tick();
        port_reg_access_i = 1'b0;
        check(emulation_port_select_o, 1'b1);
        rom_array_access_i = 1'b1;
        tick();
        rom_array_access_i = 1'b0;
        check(emulation_rom_select_o, 1'b1);
        tick();
        check(emulation_rom_select_o, 1'b0);
        boot(1'b1, 16'hFFFF);
        check(high_pins_chip_select_o, 5'h1F);
        check({addr_high_is_addr_o, chip_select_three_en_o,
            chip_select_five_en_o, grant_acknowledge_en_o}, 4'hF);
        pulse_write(1'b0, 1'b0);
        check(high_pins_chip_select_o, 5'h05);
        pulse_write(1'b1, 1'b1);
        check(low_address_disable_o, 1'b0);
        repeat (150) tick();
        check(bus_cycle_allowed_o, 1'b1);
        boot(1'b0, 16'hFFFF);
        check(low_address_disable_o, 1'b1);
        check({addr_high_is_addr_o, chip_select_three_en_o,
            chip_select_five_en_o}, 3'h0);
        pulse_write(1'b1, 1'b0);
        check(low_address_disable_o, 1'b0);
        repeat (150) tick();
        check(bus_cycle_allowed_o, 1'b0);
        print_verdict();
    end
    // about 470 cycles expected; a hang is cut at 5000
    initial begin
        #25000;
        n_errors++;
        print_verdict();
    end
endmodule // tb_reset_pin_config_select
`default_nettype wire
